/* src/smsp_core.sv */
`timescale 1ns/1ns
module smsp_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clockGateSet,
  input wire logic clockGateClear,
  input wire logic deepStop,
  input wire logic lightStop,
  input wire smsp_pkg::smsp_ctrl_t ctrl,
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  input wire logic rxReadStrobe,
  output logic [7:0] rxByte,
  output logic receiveFullFlag,
  output logic transmitEmptyFlag,
  output logic faultDetectFlag,
  input wire logic faultClear,
  output logic peripheralClockGateReg,
  output logic busy,
  input wire logic clkIn,
  input wire logic mosiIn,
  input wire logic misoIn,
  input wire logic selIn,
  output smsp_pkg::smsp_pins_t pins
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } smsp_state_t;

  smsp_state_t state_reg, state_next;
  logic [7:0] shift_reg;
  logic [3:0] edgeCnt_reg;
  logic [15:0] divCnt_reg;
  logic sclk_reg;
  logic [2:0] clkSync_reg;
  logic [1:0] selSync_reg;
  logic [1:0] mosiSync_reg;
  logic [1:0] misoSync_reg;
  logic [7:0] rx_reg;
  logic full_reg;
  logic fault_reg;
  logic gate_reg;
  logic sampled_reg;

  // Active = gated clock on, enabled, not stopped
  wire logic active;
  wire logic enabled;
  wire logic master;
  wire logic fifoValid;
  wire logic [7:0] fifoData;
  wire logic fifoPop;
  wire logic flush;
  wire logic [15:0] divisor;
  wire logic tick;
  wire logic start;
  wire logic sIn;
  wire logic sOut;
  wire logic slaveSel;
  wire logic sRise;
  wire logic sFall;
  wire logic leadEdge;
  wire logic trailEdge;
  wire logic lastEdge;
  wire logic faultIn;
  wire logic runEnd;

  // Light stop halts the block by holding its state; deep stop resets it
  assign active = gate_reg && ctrl.moduleEnable && !lightStop;
  // Pins keep their roles through light stop so the far side sees no edge
  assign enabled = gate_reg && ctrl.moduleEnable;
  assign master = ctrl.masterSelect;
  assign flush = !ctrl.moduleEnable || !gate_reg;

  // Transmit buffer: the FIFO; pop happens at transfer start
  smsp_fifo #(.WIDTH(smsp_pkg::BYTE_W), .DEPTH(smsp_pkg::FIFO_DEPTH))
    txFifo (
    .clock(clock),
    .rst_b(rst_b),
    .flush(flush),
    .inValid(txValid && gate_reg && ctrl.moduleEnable),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // Divisor = (prescale+1) * 2^rate, rate capped at RATE_MAX; it is the half-period count
  assign divisor = 16'((16'(ctrl.prescaleField) + 16'h0001)
    << ((ctrl.rateSelectField > smsp_pkg::RATE_MAX) ?
        smsp_pkg::RATE_MAX : ctrl.rateSelectField));
  assign tick = (divCnt_reg >= divisor - 16'h0001);

  // Synchronised slave pins; first stage read only by second stage
  assign slaveSel = !selSync_reg[1] && !master;
  assign sRise = clkSync_reg[1] && !clkSync_reg[2];
  assign sFall = !clkSync_reg[1] && clkSync_reg[2];

  // Polarity flips which pin edge is the leading one
  assign leadEdge = master ? tick :
    (ctrl.clockPolarity ? sFall : sRise);
  assign trailEdge = master ? tick :
    (ctrl.clockPolarity ? sRise : sFall);
  assign lastEdge = edgeCnt_reg == smsp_pkg::BIT_LAST;

  // Data in: master reads master-in, slave reads master-out; single-wire
  // uses the shared line. Master samples its own clock's timing, so a
  // synchroniser there would cost two cycles and break the fastest rates
  assign sIn = master ?
    (ctrl.singleWireSelect ? mosiIn : misoIn) :
    (ctrl.singleWireSelect ? misoSync_reg[1] : mosiSync_reg[1]);
  assign sOut = ctrl.shiftDirection ? shift_reg[0] : shift_reg[7];

  assign faultIn = master && ctrl.faultDetectEnable &&
    !ctrl.selectOutputEnable && !selSync_reg[1];

  assign start = (state_reg == ST_IDLE) && active && fifoValid &&
    (master ? !faultIn : slaveSel);
  assign fifoPop = start;
  assign runEnd = (state_reg == ST_RUN) && lastEdge &&
    (master ? tick : (edgeCnt_reg[0] ? trailEdge : leadEdge));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!active || (!master && !slaveSel) || faultIn) begin
          state_next = ST_IDLE;
        end else if (runEnd) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gate_reg <= 1'b0;
    end else if (deepStop) begin
      gate_reg <= 1'b0;
    end else if (clockGateSet) begin
      gate_reg <= 1'b1;
    end else if (clockGateClear) begin
      gate_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clkSync_reg <= 3'h0;
      selSync_reg <= 2'h3;
      mosiSync_reg <= 2'h0;
      misoSync_reg <= 2'h0;
    end else begin
      clkSync_reg <= {clkSync_reg[1:0], clkIn};
      selSync_reg <= {selSync_reg[0], selIn};
      mosiSync_reg <= {mosiSync_reg[0], mosiIn};
      misoSync_reg <= {misoSync_reg[0], misoIn};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      divCnt_reg <= smsp_pkg::DIV_RESET;
    end else if (deepStop || flush) begin
      state_reg <= ST_IDLE;
      divCnt_reg <= smsp_pkg::DIV_RESET;
    end else if (!lightStop) begin
      state_reg <= state_next;
      divCnt_reg <= (state_reg != ST_RUN || tick) ? smsp_pkg::DIV_RESET :
        divCnt_reg + 16'h0001;
    end
  end

  // Sixteen half-bit edges make one byte; odd edges trail
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= smsp_pkg::SHIFT_RESET;
      edgeCnt_reg <= smsp_pkg::EDGE_RESET;
      sclk_reg <= 1'b0;
      sampled_reg <= 1'b0;
    end else if (start) begin
      shift_reg <= fifoData;
      edgeCnt_reg <= smsp_pkg::EDGE_RESET;
      sclk_reg <= 1'b0;
    end else if (state_reg == ST_RUN && active) begin
      if (master ? tick : (edgeCnt_reg[0] ? trailEdge : leadEdge)) begin
        edgeCnt_reg <= edgeCnt_reg + 4'h1;
        sclk_reg <= !sclk_reg;
        // Phase 0 samples on even edges, phase 1 on odd edges
        if (edgeCnt_reg[0] == ctrl.clockPhase) begin
          sampled_reg <= sIn;
        end else if (edgeCnt_reg != 4'h0) begin
          // Edge 0 never shifts: the first bit must still be on the line
          shift_reg <= ctrl.shiftDirection ?
            {sampled_reg, shift_reg[7:1]} :
            {shift_reg[6:0], sampled_reg};
        end
        if (lastEdge && !ctrl.clockPhase) begin
          shift_reg <= ctrl.shiftDirection ?
            {sampled_reg, shift_reg[7:1]} : {shift_reg[6:0], sampled_reg};
        end
      end
    end else if (state_reg != ST_RUN) begin
      sclk_reg <= 1'b0;
      edgeCnt_reg <= smsp_pkg::EDGE_RESET;
    end
  end

  // Phase 1 final sample lands on last edge; merge it on completion
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_reg <= smsp_pkg::SHIFT_RESET;
      full_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (deepStop || flush) begin
      full_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (state_reg == ST_DONE) begin
        rx_reg <= ctrl.clockPhase ? (ctrl.shiftDirection ?
          {sampled_reg, shift_reg[7:1]} : {shift_reg[6:0], sampled_reg}) :
          shift_reg;
        full_reg <= 1'b1;
      end else if (rxReadStrobe) begin
        full_reg <= 1'b0;
      end
      // Set wins over a same-cycle clear
      if (faultIn && (state_reg != ST_DONE)) begin
        fault_reg <= 1'b1;
      end else if (faultClear) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // Pin routing: oe_b low means this block drives the pin
  wire logic drvClk;
  wire logic drvMosi;
  wire logic drvMiso;
  wire logic drvSel;
  assign drvClk = enabled && master;
  assign drvMosi = enabled && master &&
    (!ctrl.singleWireSelect || ctrl.singleWireOutputEnable);
  assign drvMiso = enabled && !master && slaveSel &&
    (!ctrl.singleWireSelect || ctrl.singleWireOutputEnable);
  assign drvSel = enabled && master && ctrl.faultDetectEnable &&
    ctrl.selectOutputEnable;
  assign pins.clkOut = sclk_reg ^ ctrl.clockPolarity;
  assign pins.clkOeB = !drvClk;
  assign pins.mosiOut = sOut;
  assign pins.mosiOeB = !drvMosi;
  assign pins.misoOut = sOut;
  assign pins.misoOeB = !drvMiso;
  assign pins.selOut = state_reg == ST_IDLE;
  assign pins.selOeB = !drvSel;

  assign rxByte = rx_reg;
  assign receiveFullFlag = full_reg;
  assign transmitEmptyFlag = !fifoValid;
  assign faultDetectFlag = fault_reg;
  assign peripheralClockGateReg = gate_reg;
  assign busy = state_reg != ST_IDLE;

  a_gate_reset: assert property (@(posedge clock) disable iff (!rst_b)
    deepStop |=> !peripheralClockGateReg)
    else $error("gate not cleared");
  a_disable_flush: assert property (@(posedge clock) disable iff (!rst_b)
    !ctrl.moduleEnable |=> !receiveFullFlag && !busy)
    else $error("disable did not flush");
  a_pins_released: assert property (@(posedge clock) disable iff (!rst_b)
    !ctrl.moduleEnable |-> pins.clkOeB && pins.mosiOeB && pins.misoOeB
      && pins.selOeB)
    else $error("pin driven while disabled");
  a_master_miso: assert property (@(posedge clock) disable iff (!rst_b)
    master |-> pins.misoOeB)
    else $error("master drove master-in");
  a_slave_mosi: assert property (@(posedge clock) disable iff (!rst_b)
    !master |-> pins.mosiOeB && pins.clkOeB)
    else $error("slave drove clock or master-out");
  a_idle_polarity: assert property (@(posedge clock) disable iff (!rst_b)
    state_reg == ST_IDLE && $past(state_reg) == ST_IDLE
      |-> pins.clkOut == ctrl.clockPolarity)
    else $error("clock idle level wrong");
  sequence s_done;
    state_reg == ST_DONE;
  endsequence
  a_done_full: assert property (@(posedge clock) disable iff (!rst_b)
    s_done ##0 active |=> receiveFullFlag)
    else $error("receive buffer not filled");
  a_byte_edges: assert property (@(posedge clock) disable iff (!rst_b)
    s_done |-> $past(edgeCnt_reg) == 4'hF)
    else $error("transfer not 16 edges");
endmodule // smsp_core

/* src/smsp_fifo.sv */
`timescale 1ns/1ns
module smsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  wire logic doWrite;
  wire logic doRead;
  assign inReady = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign doWrite = inValid && inReady && !flush;
  assign doRead = outValid && outReady && !flush;
  assign outData = mem[rdPtr_reg[AW-1:0]];
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_reg + (AW+1)'(doWrite);
      rdPtr_reg <= rdPtr_reg + (AW+1)'(doRead);
    end
  end
endmodule // smsp_fifo

/* src/smsp_pkg.sv */
package smsp_pkg;
  // Control word taken from ports
  typedef struct packed {
    logic moduleEnable;
    logic masterSelect;
    logic clockPolarity;
    logic clockPhase;
    logic shiftDirection;
    logic singleWireSelect;
    logic singleWireOutputEnable;
    logic faultDetectEnable;
    logic selectOutputEnable;
    logic [2:0] prescaleField;
    logic [3:0] rateSelectField;
  } smsp_ctrl_t;

  // Pin bundle: out, oe_b per pin
  typedef struct packed {
    logic clkOut;
    logic clkOeB;
    logic mosiOut;
    logic mosiOeB;
    logic misoOut;
    logic misoOeB;
    logic selOut;
    logic selOeB;
  } smsp_pins_t;

  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] RATE_MAX = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [3:0] EDGE_RESET = 4'h0;
endpackage

/* tb/smsp_peer.sv */
`timescale 1ns/1ns
// Slave on the far side of the port, behavioural
module smsp_peer (
  input wire logic sck,
  input wire logic sel,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsbFirst,
  input wire logic [7:0] loadByte,
  output logic miso,
  output logic [7:0] gotByte
);
  logic [7:0] txSh;
  logic [7:0] rxSh;
  int n;
  task automatic putBit();
    miso <= #1 (lsbFirst ? txSh[0] : txSh[7]);
    txSh = lsbFirst ? {1'b0, txSh[7:1]} : {txSh[6:0], 1'b0};
  endtask
  initial begin
    miso = 1'b0;
    gotByte = 8'h00;
    rxSh = 8'h00;
    n = 0;
  end
  always @(negedge sel) begin
    txSh = loadByte;
    n = 0;
    if (!cpha) putBit();
  end
  // Released line flips so a stale bit never passes for data
  always @(posedge sel) miso <= #1 ~miso;
  always @(sck) begin
    if (sel === 1'b0) begin
      if ((sck !== cpol) == !cpha) begin
        rxSh = lsbFirst ? {mosi, rxSh[7:1]} : {rxSh[6:0], mosi};
        n = n + 1;
        if (n == 8) gotByte = rxSh;
      end else begin
        putBit();
      end
    end
  end
endmodule // smsp_peer

/* tb/spi_master_slave_port_tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %0h want %0h", $time, a, b); end end
module spi_master_slave_port_tb;
  logic clock, rst_b, gateSet, gateClr, deepStop, lightStop, txValid;
  logic rxRead, faultClr, selForce, lastClk;
  smsp_pkg::smsp_ctrl_t ctrl;
  smsp_pkg::smsp_pins_t pins;
  logic [7:0] txData, peerLoad, rxByte, peerGot, txb;
  logic txReady, full, empty, fault, gate, busy, misoLine;
  logic clkIn, mosiIn, misoIn, selIn;
  logic [31:0] seed, w;
  int error_cnt, num_checks, cyc, togCnt, gap, lastT, acc, half, p, r, k;
  int base, base2;
  assign clkIn = pins.clkOeB ? ctrl.clockPolarity : pins.clkOut;
  assign mosiIn = pins.mosiOeB ? ~pins.mosiOut : pins.mosiOut;
  assign misoIn = pins.misoOeB ? misoLine : pins.misoOut;
  assign selIn = pins.selOeB ? selForce : pins.selOut;
  smsp_core u_smsp_core (.clock(clock), .rst_b(rst_b),
    .clockGateSet(gateSet), .clockGateClear(gateClr), .deepStop(deepStop),
    .lightStop(lightStop), .ctrl(ctrl), .txValid(txValid),
    .txReady(txReady), .txData(txData), .rxReadStrobe(rxRead),
    .rxByte(rxByte), .receiveFullFlag(full), .transmitEmptyFlag(empty),
    .faultDetectFlag(fault), .faultClear(faultClr),
    .peripheralClockGateReg(gate), .busy(busy), .clkIn(clkIn),
    .mosiIn(mosiIn), .misoIn(misoIn), .selIn(selIn), .pins(pins));
  smsp_peer u_smsp_peer (.sck(clkIn), .sel(selIn), .mosi(mosiIn),
    .cpol(ctrl.clockPolarity), .cpha(ctrl.clockPhase),
    .lsbFirst(ctrl.shiftDirection), .loadByte(peerLoad), .miso(misoLine),
    .gotByte(peerGot));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task give_verdict();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Sampled off the launching edge; counts clock pin toggles and gaps
  always @(negedge clock) begin
    cyc++;
    if (pins.clkOut !== lastClk) begin
      togCnt++;
      gap = cyc - lastT;
      lastT = cyc;
    end
    lastClk = pins.clkOut;
    if (cyc == 80000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task put(input logic [7:0] b);
    @(negedge clock);
    txData = b;
    txValid = 1'b1;
    @(negedge clock);
    txValid = 1'b0;
  endtask
  task pinChk(input logic en, ms, sw, oe, fe, so, input logic [3:0] ex, m);
    ctrl.moduleEnable = en;
    ctrl.masterSelect = ms;
    ctrl.singleWireSelect = sw;
    ctrl.singleWireOutputEnable = oe;
    ctrl.faultDetectEnable = fe;
    ctrl.selectOutputEnable = so;
    repeat (3) @(negedge clock);
    `CHK({pins.clkOeB, pins.mosiOeB, pins.misoOeB, pins.selOeB} & m, ex);
  endtask
  task xfer(input int i);
    w = xs();
    ctrl.clockPolarity = i[0];
    ctrl.clockPhase = i[1];
    ctrl.shiftDirection = i[2];
    p = (i == 9) ? 0 : int'(w[18:16]);
    r = (i == 9) ? 9 : ((i == 2) ? 2 : int'(w[31:24]) % 3);
    ctrl.prescaleField = p[2:0];
    ctrl.rateSelectField = r[3:0];
    peerLoad = w[7:0];
    txb = w[15:8];
    half = (p + 1) << ((r > 8) ? 8 : r);
    repeat (2) @(negedge clock);
    base = togCnt;
    put(txb);
    if (i == 2) begin
      repeat (10) @(negedge clock);
      lightStop = 1'b1;
      base2 = togCnt;
      repeat (100) @(negedge clock);
      `CHK(togCnt, base2);
      `CHK(busy, 1'b1);
      lightStop = 1'b0;
    end
    for (k = 0; k < 9000 && full !== 1'b1; k++) @(negedge clock);
    `CHK(rxByte, peerLoad);
    `CHK(peerGot, txb);
    `CHK(togCnt - base, 16);
    `CHK(gap, half);
    `CHK(pins.clkOut, ctrl.clockPolarity);
    rxRead = 1'b1;
    @(negedge clock);
    rxRead = 1'b0;
    @(negedge clock);
    `CHK(full, 1'b0);
  endtask
  initial begin
    {gateSet, gateClr, deepStop, lightStop, txValid, rxRead} = 6'h00;
    {faultClr, rst_b, txData, peerLoad, txb} = 26'h0000000;
    ctrl = '0;
    selForce = 1'b1;
    seed = 32'h00007788;
    {error_cnt, num_checks, cyc, togCnt, gap, lastT} = '0;
    lastClk = 1'b0;
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    `CHK(gate, 1'b0);
    pinChk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 4'hF);
    put(8'hA5);
    repeat (40) @(negedge clock);
    `CHK({busy, full}, 2'b00);
    gateSet = 1'b1;
    @(negedge clock);
    gateSet = 1'b0;
    `CHK(gate, 1'b1);
    pinChk(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 4'hF);
    pinChk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 4'hF);
    pinChk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 4'hF);
    pinChk(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h7, 4'hF);
    pinChk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hD, 4'hD);
    pinChk(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 4'hF);
    pinChk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h3, 4'hF);
    selForce = 1'b0;
    repeat (8) @(negedge clock);
    `CHK(fault, 1'b1);
    selForce = 1'b1;
    repeat (3) @(negedge clock);
    faultClr = 1'b1;
    @(negedge clock);
    faultClr = 1'b0;
    @(negedge clock);
    `CHK(fault, 1'b0);
    // Slow rate keeps the shifter busy while the buffer fills
    pinChk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h2, 4'hF);
    ctrl.prescaleField = 3'h7;
    ctrl.rateSelectField = 4'h3;
    txValid = 1'b1;
    acc = 0;
    for (k = 0; k < 40; k++) begin
      w = xs();
      txData = w[7:0];
      if (txReady === 1'b1) acc++;
      @(negedge clock);
    end
    txValid = 1'b0;
    `CHK(txReady, 1'b0);
    `CHK(acc == 32 || acc == 33, 1'b1);
    `CHK(empty, 1'b0);
    ctrl.moduleEnable = 1'b0;
    repeat (3) @(negedge clock);
    `CHK({busy, full, empty}, 3'b001);
    ctrl.moduleEnable = 1'b1;
    for (int i = 0; i < 10; i++) xfer(i);
    deepStop = 1'b1;
    @(negedge clock);
    deepStop = 1'b0;
    @(negedge clock);
    `CHK({gate, full, busy}, 3'b000);
    give_verdict();
  end
endmodule // spi_master_slave_port_tb
